// >>> pkg/mdd_defs.vh
// Command encodings, field positions and timing counts for the command sequencer
`ifndef MDD_DEFS_VH
`define MDD_DEFS_VH

`define MDD_CLK_PERIOD_NS 20
`define MDD_TRFC_NS 72
`define MDD_TXSR_NS 120
`define MDD_TRFC_CYC (((`MDD_TRFC_NS) + (`MDD_CLK_PERIOD_NS) - 1) / (`MDD_CLK_PERIOD_NS))
`define MDD_TXSR_CYC (((`MDD_TXSR_NS) + (`MDD_CLK_PERIOD_NS) - 1) / (`MDD_CLK_PERIOD_NS))
`define MDD_CL 2

// {cs_n, ras_n, cas_n, we_n}
`define MDD_CMD_NOP 4'h7
`define MDD_CMD_ACT 4'h3
`define MDD_CMD_RD 4'h5
`define MDD_CMD_WR 4'h4
`define MDD_CMD_PRE 4'h2
`define MDD_CMD_REF 4'h1
`define MDD_CMD_LMR 4'h0

`define MDD_A10 10
`define MDD_BT_BIT 3
`define MDD_BL_LSB 0
`define MDD_BL_W 3
`define MDD_COL_W 9
`define MDD_ROW_W 13
`define MDD_CNT_W 8

`endif

// >>> hw/mdd_cmd_seq.v
// Mobile DDR command sequencer: bank state, power states, refresh, read/write lanes
`timescale 1ns/1ns
`include "mdd_defs.vh"

module mdd_cmd_seq (
  input wire ref_clk,
  input wire rst,
  input wire cke,
  input wire cs_n,
  input wire ras_n,
  input wire cas_n,
  input wire we_n,
  input wire [1:0] bank_addr,
  input wire [12:0] addr,
  input wire [31:0] wr_data,
  input wire [3:0] byte_strobe_in,
  input wire [3:0] byte_write_mask,
  input wire [31:0] rd_data_src,
  output reg [31:0] rd_data,
  output reg [31:0] rd_data_oe,
  output reg [3:0] byte_strobe_out,
  output reg [3:0] byte_strobe_oe,
  output reg wr_en,
  output reg [1:0] wr_bank,
  output reg [12:0] wr_row,
  output reg [8:0] wr_col,
  output reg [31:0] wr_data_out,
  output reg [3:0] wr_byte_en,
  output reg rd_req,
  output reg [1:0] rd_bank,
  output reg [12:0] rd_row,
  output reg [8:0] rd_col,
  output reg [3:0] bank_open,
  output reg in_active_pd,
  output reg in_precharge_pd,
  output reg in_self_refresh,
  output reg refresh_busy,
  output reg [12:0] mode_reg
);

  localparam ST_IDLE = 5'h01;
  localparam ST_APD = 5'h02;
  localparam ST_PPD = 5'h04;
  localparam ST_SREF = 5'h08;
  localparam ST_XSR = 5'h10;
  localparam [2:0] RD_LAT = `MDD_CL - 1;
  localparam [`MDD_CNT_W-1:0] TRFC_CNT = `MDD_TRFC_CYC;
  localparam [`MDD_CNT_W-1:0] TXSR_CNT = `MDD_TXSR_CYC;
  localparam [`MDD_CNT_W-1:0] CNT_ONE = {{(`MDD_CNT_W-1){1'b0}}, 1'b1};

  reg [4:0] state;
  reg [`MDD_CNT_W-1:0] busy_cnt;
  reg [12:0] open_row [0:3];
  reg [3:0] auto_pre;
  reg burst_rd;
  reg burst_wr;
  reg [2:0] beat_left;
  reg [2:0] beat_idx;
  reg [8:0] burst_col;
  reg [1:0] burst_bank;
  reg [2:0] lat_cnt;
  wire [3:0] cmd;
  wire access_busy;
  wire [3:0] last_beat;
  integer i;

  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign access_busy = burst_rd | burst_wr;
  assign last_beat = burst_beats(mode_reg[`MDD_BL_LSB+:`MDD_BL_W]) - 4'h1;

  // Burst length in beats from the programmed mode field
  function [3:0] burst_beats;
    input [2:0] bl;
    begin
      case (bl)
        3'h1: burst_beats = 4'h2;
        3'h2: burst_beats = 4'h4;
        default: burst_beats = 4'h8;
      endcase
    end
  endfunction

  // Column of a beat: start column, then sequential or interleaved wrap
  function [8:0] beat_col;
    input [8:0] start;
    input [2:0] idx;
    input [2:0] bl;
    input bt;
    reg [2:0] low;
    reg [2:0] mask;
    reg [3:0] span;
    begin
      span = burst_beats(bl) - 4'h1;
      mask = span[2:0];
      low = bt ? (start[2:0] ^ idx) : (start[2:0] + idx);
      beat_col = {start[8:3], (start[2:0] & ~mask) | (low & mask)};
    end
  endfunction

  // --------------------------------------------------------------
  // Command decode and power states
  // --------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      busy_cnt <= {`MDD_CNT_W{1'b0}};
      bank_open <= 4'h0;
      auto_pre <= 4'h0;
      mode_reg <= 13'h0000;
      refresh_busy <= 1'b0;
      in_active_pd <= 1'b0;
      in_precharge_pd <= 1'b0;
      in_self_refresh <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
        open_row[i] <= 13'h0000;
    end
    else
    begin
      // Busy drops on the edge that empties the counter
      if (busy_cnt != {`MDD_CNT_W{1'b0}})
      begin
        busy_cnt <= busy_cnt - 1'b1;
        if (busy_cnt == CNT_ONE)
          refresh_busy <= 1'b0;
      end
      case (state)
        ST_IDLE:
        begin
          if (!cke && cmd == `MDD_CMD_REF && bank_open == 4'h0)
          begin
            state <= ST_SREF;
            in_self_refresh <= 1'b1;
          end
          else if (!cke && !access_busy && !refresh_busy)
          begin
            if (bank_open != 4'h0 || (cmd == `MDD_CMD_ACT && !cs_n))
            begin
              state <= ST_APD;
              in_active_pd <= 1'b1;
            end
            else
            begin
              state <= ST_PPD;
              in_precharge_pd <= 1'b1;
            end
          end
          if (cke && !refresh_busy)
          begin
            if (cmd == `MDD_CMD_ACT)
            begin
              bank_open[bank_addr] <= 1'b1;
              open_row[bank_addr] <= addr;
            end
            else if (cmd == `MDD_CMD_PRE)
            begin
              if (addr[`MDD_A10])
                bank_open <= 4'h0;
              else
                bank_open[bank_addr] <= 1'b0;
            end
            else if (cmd == `MDD_CMD_REF && bank_open == 4'h0)
            begin
              busy_cnt <= TRFC_CNT;
              refresh_busy <= 1'b1;
            end
            else if (cmd == `MDD_CMD_LMR && bank_addr == 2'h0)
              mode_reg <= addr;
            else if ((cmd == `MDD_CMD_RD || cmd == `MDD_CMD_WR) && addr[`MDD_A10])
              auto_pre[bank_addr] <= 1'b1;
          end
          if (!access_busy && auto_pre != 4'h0)
          begin
            bank_open <= bank_open & ~auto_pre;
            auto_pre <= 4'h0;
          end
        end
        ST_APD, ST_PPD:
          if (cke)
          begin
            state <= ST_IDLE;
            in_active_pd <= 1'b0;
            in_precharge_pd <= 1'b0;
          end
        ST_SREF:
          if (cke)
          begin
            state <= ST_XSR;
            in_self_refresh <= 1'b0;
            busy_cnt <= TXSR_CNT;
            refresh_busy <= 1'b1;
          end
        ST_XSR:
          if (busy_cnt == CNT_ONE)
            state <= ST_IDLE;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Burst engine for reads and writes
  // --------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      burst_rd <= 1'b0;
      burst_wr <= 1'b0;
      beat_left <= 3'h0;
      beat_idx <= 3'h0;
      burst_col <= 9'h000;
      burst_bank <= 2'h0;
      lat_cnt <= 3'h0;
      wr_en <= 1'b0;
      wr_bank <= 2'h0;
      wr_row <= 13'h0000;
      wr_col <= 9'h000;
      wr_data_out <= 32'h00000000;
      wr_byte_en <= 4'h0;
      rd_req <= 1'b0;
      rd_bank <= 2'h0;
      rd_row <= 13'h0000;
      rd_col <= 9'h000;
      rd_data <= 32'h00000000;
      rd_data_oe <= 32'h00000000;
      byte_strobe_out <= 4'h0;
      byte_strobe_oe <= 4'h0;
    end
    else
    begin
      wr_en <= 1'b0;
      rd_req <= 1'b0;
      if (state == ST_IDLE && cke && !refresh_busy && !access_busy &&
          (cmd == `MDD_CMD_RD || cmd == `MDD_CMD_WR) && bank_open[bank_addr])
      begin
        burst_rd <= (cmd == `MDD_CMD_RD);
        burst_wr <= (cmd == `MDD_CMD_WR);
        burst_col <= addr[`MDD_COL_W-1:0];
        burst_bank <= bank_addr;
        beat_idx <= 3'h0;
        beat_left <= last_beat[2:0];
        lat_cnt <= (cmd == `MDD_CMD_RD) ? RD_LAT : 3'h0;
      end
      else if (access_busy)
      begin
        if (lat_cnt != 3'h0)
          lat_cnt <= lat_cnt - 3'h1;
        else
        begin
          beat_idx <= beat_idx + 3'h1;
          if (beat_left == 3'h0)
          begin
            burst_rd <= 1'b0;
            burst_wr <= 1'b0;
          end
          else
            beat_left <= beat_left - 3'h1;
          if (burst_wr)
          begin
            wr_en <= 1'b1;
            wr_bank <= burst_bank;
            wr_row <= open_row[burst_bank];
            wr_col <= beat_col(burst_col, beat_idx, mode_reg[`MDD_BL_LSB+:`MDD_BL_W],
                               mode_reg[`MDD_BT_BIT]);
            wr_data_out <= wr_data;
            wr_byte_en <= byte_strobe_in & ~byte_write_mask;
          end
          else
          begin
            rd_req <= 1'b1;
            rd_bank <= burst_bank;
            rd_row <= open_row[burst_bank];
            rd_col <= beat_col(burst_col, beat_idx, mode_reg[`MDD_BL_LSB+:`MDD_BL_W],
                               mode_reg[`MDD_BT_BIT]);
          end
        end
      end
      // Read data and per-byte strobes leave together, one cycle after fetch
      rd_data <= rd_req ? rd_data_src : 32'h00000000;
      rd_data_oe <= {32{rd_req}};
      byte_strobe_out <= rd_req ? {4{beat_idx[0]}} : 4'h0;
      byte_strobe_oe <= {4{rd_req}};
    end
  end

endmodule

// >>> test/mdd_host.sv
// Host controller model driving commands, clock enable and write lanes
`timescale 1ns/1ns
`include "mdd_defs.vh"
module mdd_host (
  input wire ref_clk,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [1:0] bank_addr,
  output logic [12:0] addr,
  output logic [31:0] wr_data,
  output logic [3:0] byte_strobe_in,
  output logic [3:0] byte_write_mask
);
  initial
  begin
    {cke, cs_n, ras_n, cas_n, we_n} = 5'h1F;
    {bank_addr, addr} = 15'h0000;
    {byte_strobe_in, byte_write_mask} = 8'hF2;
    wr_data = 32'h12345678;
  end
  // One command, then NOP with the address lines inverted
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a, input logic k);
    @(negedge ref_clk);
    {cs_n, ras_n, cas_n, we_n} = c;
    {bank_addr, addr, cke} = {b, a, k};
    if (c == `MDD_CMD_REF)
      wr_data = ~wr_data;
    @(negedge ref_clk);
    {cs_n, ras_n, cas_n, we_n} = `MDD_CMD_NOP;
    addr = ~a;
  endtask
  task automatic nops(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic init_seq;
    nops(10000);
    cmd(`MDD_CMD_PRE, 2'h0, 13'h0400, 1'b1);
    cmd(`MDD_CMD_REF, 2'h0, 13'h0000, 1'b1);
    nops(4);
    cmd(`MDD_CMD_REF, 2'h0, 13'h0000, 1'b1);
    nops(4);
    cmd(`MDD_CMD_LMR, 2'h0, 13'h0002, 1'b1);
  endtask
endmodule

// >>> test/mdd_cmd_seq_monitor.sv
// Port-level assertions for the command sequencer
`timescale 1ns/1ns
`include "mdd_defs.vh"
module mdd_cmd_seq_monitor (
  input wire ref_clk,
  input wire rst,
  input wire cke,
  input wire cs_n,
  input wire ras_n,
  input wire cas_n,
  input wire we_n,
  input wire [1:0] bank_addr,
  input wire [12:0] addr,
  input wire wr_en,
  input wire [8:0] wr_col,
  input wire rd_req,
  input wire [3:0] bank_open,
  input wire in_active_pd,
  input wire in_precharge_pd,
  input wire in_self_refresh,
  input wire refresh_busy
);
  wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
  wire pd = in_active_pd || in_precharge_pd;
  wire calm = !refresh_busy && !wr_en && !rd_req && !in_self_refresh && !pd;
  wire go = cke && calm;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_rfc;
    refresh_busy [*4] ##1 !refresh_busy;
  endsequence
  chk_write_start: assert property (go && cmd == `MDD_CMD_WR && bank_open[bank_addr] |->
    ##2 wr_en && {4'h0, wr_col} == ($past(addr, 2) & 13'h01FF)) else $error("write start wrong");
  chk_read_start: assert property (go && cmd == `MDD_CMD_RD && bank_open[bank_addr] |->
    ##3 rd_req) else $error("read latency wrong");
  chk_pd_kind: assert property (!cke && $past(cke) && cmd == `MDD_CMD_NOP && calm |=>
    in_active_pd == ($past(bank_open) != 4'h0) && in_precharge_pd == ($past(bank_open) == 4'h0))
    else $error("power-down kind wrong");
  chk_pd_exit: assert property (pd && cke |=> !pd) else $error("power-down exit wrong");
  chk_refresh_time: assert property (go && cmd == `MDD_CMD_REF && bank_open == 4'h0 |=> s_rfc)
    else $error("refresh time wrong");
  chk_busy_refuse: assert property (refresh_busy && cmd == `MDD_CMD_ACT |=>
    bank_open == $past(bank_open)) else $error("command taken while busy");
  chk_sref_hold: assert property (in_self_refresh && !cke |=> in_self_refresh) else $error("self refresh left");
  chk_sref_exit: assert property (in_self_refresh && cke |=> !in_self_refresh) else $error("self refresh stuck");
endmodule
bind mdd_cmd_seq mdd_cmd_seq_monitor chk (.*);

// >>> test/mdd_cmd_seq_tb.sv
// Self-checking bench for the command sequencer with a host model
`timescale 1ns/1ns
`include "mdd_defs.vh"
module mdd_cmd_seq_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] rd_data_src = 32'hA5C31E78;
  logic cke, cs_n, ras_n, cas_n, we_n, wr_en, rd_req, in_active_pd, in_precharge_pd, in_self_refresh, refresh_busy;
  logic [1:0] bank_addr, wr_bank, rd_bank;
  logic [12:0] addr, wr_row, rd_row, mode_reg;
  logic [8:0] wr_col, rd_col;
  logic [31:0] wr_data, rd_data, rd_data_oe, wr_data_out;
  logic [3:0] byte_strobe_in, byte_write_mask, byte_strobe_out, byte_strobe_oe, wr_byte_en, bank_open;
  int err_count = 0;
  int checks_done = 0;
  int n, m;
  always #10 ref_clk = ~ref_clk;
  mdd_host host (.*);
  mdd_cmd_seq dut (.*);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    if (got !== exp)
      err_count++;
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_refresh;
    host.cmd(`MDD_CMD_REF, 2'h0, 13'h0000, 1'b1);
    check(32'(refresh_busy), 32'h1);
    host.cmd(`MDD_CMD_ACT, 2'h1, 13'h0055, 1'b1);
    check(32'(bank_open), 32'h0);
    host.nops(6);
  endtask
  task automatic t_write;
    host.cmd(`MDD_CMD_ACT, 2'h1, 13'h0123, 1'b1);
    host.cmd(`MDD_CMD_WR, 2'h1, 13'h0006, 1'b1);
    n = 0;
    repeat (8)
    begin
      if (wr_en === 1'b1)
        check(32'({wr_col, wr_byte_en}), ((32'h4 | ((32'h6 + n) & 32'h3)) << 4) | 32'hD);
      if (wr_en === 1'b1)
        n++;
      @(negedge ref_clk);
    end
    check(n, 4);
  endtask
  task automatic t_read;
    host.cmd(`MDD_CMD_RD, 2'h1, 13'h0405, 1'b1);
    {n, m} = 64'h0;
    repeat (10)
    begin
      if (rd_req === 1'b1)
        check(32'(rd_col), 32'h4 | ((32'h5 + n) & 32'h3));
      if (rd_req === 1'b1)
        n++;
      if (rd_data_oe === 32'hFFFFFFFF)
        check(rd_data ^ {28'h0, byte_strobe_oe}, rd_data_src ^ 32'hF);
      if (rd_data_oe === 32'hFFFFFFFF)
        m++;
      @(negedge ref_clk);
    end
    check(n + 4 * m, 20);
    check(32'(bank_open), 32'h0);
  endtask
  task automatic t_power;
    host.cmd(`MDD_CMD_ACT, 2'h2, 13'h0077, 1'b1);
    host.cmd(`MDD_CMD_NOP, 2'h0, 13'h0000, 1'b0);
    check(32'({in_active_pd, in_precharge_pd}), 32'h2);
    host.cmd(`MDD_CMD_NOP, 2'h0, 13'h0000, 1'b1);
    check(32'({in_active_pd, in_precharge_pd}), 32'h0);
    host.nops(1);
    host.cmd(`MDD_CMD_PRE, 2'h0, 13'h0400, 1'b1);
    host.cmd(`MDD_CMD_NOP, 2'h0, 13'h0000, 1'b0);
    check(32'({in_active_pd, in_precharge_pd}), 32'h1);
    host.cmd(`MDD_CMD_NOP, 2'h0, 13'h0000, 1'b1);
    host.nops(1);
  endtask
  task automatic t_sref;
    host.cmd(`MDD_CMD_REF, 2'h0, 13'h0000, 1'b0);
    host.nops(20);
    check(32'(in_self_refresh), 32'h1);
    host.cmd(`MDD_CMD_NOP, 2'h0, 13'h0000, 1'b1);
    check(32'(in_self_refresh), 32'h0);
    host.nops(6);
    host.cmd(`MDD_CMD_ACT, 2'h3, 13'h0011, 1'b1);
    check(32'(bank_open), 32'h8);
  endtask
  initial
  begin
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
    host.init_seq();
    check(32'(mode_reg), 32'h2);
    t_refresh();
    t_write();
    t_read();
    t_power();
    t_sref();
    complete_run();
  end
  initial
  begin
    #400000;
    err_count++;
    complete_run();
  end
endmodule
